// file: tsas_defs.svh
// Purpose: constants of the touch adc serial sequencer
// Assumes: command byte arrives msb first on the serial input
// Notes:   positions, codes and counts only; types live in tsas_pkg
// Contract
// R1: command byte msb is always one
// R2: idle device ignores input until start bit
// R3: three bits after start select channel
// R4: bit three low twelve bits, high eight
// R5: bit two high single-ended, low differential
// R6: two low bits select power-down mode
// R7: host runs eight-clock transfers, twenty-four total
// R8: first eight clocks carry command, then acquire; code acquires from the fifth clock's fall, inside the command
// R9: after three acquire clocks hold and convert
// R10: conversion spans twelve clocks after acquisition
// R11: differential keeps drivers on, thirteenth clock
// R12: padding clocks ignored, result output low
// R13: channel zero biases low-current temperature diode
// R14: channel seven biases diode ninety-one times higher
// R15: diode bias only during three acquire clocks
// R16: battery divider only sampling channel two
// R17: single-ended uses pin reference, else panel
// R18: host should use eight bits for pressure
// R19: next command every fifteenth or eleventh clock
// R20: power-down encodings control reference and converter
// R21: touch alert re-enabled at end of conversion; code does so only when the converter power bit is low
// R22: result shifted out msb first per clock
`ifndef TSAS_DEFS_SVH
`define TSAS_DEFS_SVH

`define TSAS_START_POS     7
`define TSAS_CHAN_MSB      6
`define TSAS_CHAN_LSB      4
`define TSAS_MODE_POS      3
`define TSAS_REF_POS       2
`define TSAS_PD1_POS       1
`define TSAS_PD0_POS       0

`define TSAS_CH_DIODE_LOW  3'h0
`define TSAS_CH_DIODE_HIGH 3'h7
`define TSAS_CH_BATTERY    3'h2

`define TSAS_ACQ_AT_BIT    5'h05
`define TSAS_CMD_BITS      5'h08
`define TSAS_CNT_MAX       5'h1F
`define TSAS_NEXT_12BIT    5'h0F
`define TSAS_NEXT_8BIT     5'h0B

`define TSAS_LAST_12BIT    4'hB
`define TSAS_LAST_8BIT     4'h7

`endif

// file: tsas_host_model.sv
// Purpose: host serial port driving the shift clock and command pin
// Assumes: eight system clocks per shift clock period
// Notes:   shift clock stands low between frames
`timescale 1ns/1ns
`default_nettype none
module tsas_host_model (
  input  wire logic clk,                 // system clock
  input  wire logic serial_data_out_r,   // result pin
  output var  logic serial_shift_clock,  // shift clock to device
  output var  logic serial_data_in       // command pin
);
  initial begin
    serial_shift_clock = 1'b0;
    serial_data_in = 1'b0;
  end

  // left-aligned bits, msb first; result read well after each rise
  task automatic xfer(input logic [31:0] bits, input int n,
                      output logic [31:0] got);
    got = 32'h0000_0000;
    for (int i = 0; i < n; i++) begin
      @(posedge clk) serial_data_in <= bits[31-i];
      repeat (3) @(posedge clk);
      serial_shift_clock <= 1'b1;
      repeat (2) @(posedge clk);
      got = {got[30:0], serial_data_out_r};
      repeat (2) @(posedge clk);
      serial_shift_clock <= 1'b0;
    end
    @(posedge clk) serial_data_in <= ~serial_data_in;
  endtask : xfer
endmodule : tsas_host_model
`default_nettype wire

// file: tsas_pkg.sv
// Purpose: shared types of the touch adc serial sequencer
// Assumes: nothing beyond standard packed types
// Notes:   constants are in tsas_defs.svh
package tsas_pkg;

  typedef enum logic [0:0] {
    TSAS_RX_IDLE = 1'b0,
    TSAS_RX_CMD  = 1'b1
  } tsas_rx_e;

  typedef enum logic [1:0] {
    TSAS_CV_IDLE = 2'b00,
    TSAS_CV_ACQ  = 2'b01,
    TSAS_CV_CONV = 2'b10,
    TSAS_CV_TAIL = 2'b11
  } tsas_cv_e;

  typedef struct packed {
    logic [2:0] channel_select;
    logic       res_8bit;
    logic       reference_mode_select;
    logic       reference_power_bit;
    logic       converter_power_bit;
  } tsas_cmd_s;

  typedef struct packed {
    logic drivers_on;
    logic sample_hold;
    logic diode_low_current_sample;
    logic diode_high_current_sample;
    logic battery_divider_on;
    logic ref_from_pin;
  } tsas_ana_s;

endpackage : tsas_pkg

// file: tsas_sar.sv
// Purpose: successive-approximation register, one decision per step
// Assumes: comparator_keep high when input is at or above trial code
// Notes:   eight-bit conversions simply stop after eight steps
`timescale 1ns/1ns
`default_nettype none
module tsas_sar #(
  parameter int BITS = 12
) (
  input  wire logic            clk,          // system clock
  input  wire logic            reset,        // sync reset, high
  input  wire logic            start,        // load msb trial
  input  wire logic            step,         // decide current bit
  input  wire logic            comparator_keep, // keep trial bit
  output var  logic [BITS-1:0] trial_code_r, // code to the cdac
  output var  logic            decided_r     // last decided bit
);

  if (BITS < 8) begin : g_chk
    $error("tsas_sar: BITS must be at least eight");
  end

  logic [BITS-1:0] mask_r;
  logic [BITS-1:0] mask_nxt;
  logic [BITS-1:0] trial_code_nxt;
  logic            decided_nxt;

  always_comb begin
    mask_nxt       = mask_r;
    trial_code_nxt = trial_code_r;
    decided_nxt    = decided_r;
    if (start) begin
      mask_nxt       = {1'b1, {(BITS-1){1'b0}}};
      trial_code_nxt = {1'b1, {(BITS-1){1'b0}}};
    end else if (step) begin
      mask_nxt       = mask_r >> 1;
      trial_code_nxt = (comparator_keep ? trial_code_r
                                        : (trial_code_r & ~mask_r))
                       | (mask_r >> 1);
      decided_nxt    = comparator_keep;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mask_r       <= '0;
      trial_code_r <= '0;
      decided_r    <= 1'b0;
    end else begin
      mask_r       <= mask_nxt;
      trial_code_r <= trial_code_nxt;
      decided_r    <= decided_nxt;
    end
  end

endmodule : tsas_sar
`default_nettype wire

// file: tsas_sequencer.sv
// Purpose: serial command receiver and conversion sequencer
// Assumes: shift clock, serial input, comparator and touch sense are async
// Notes:   input sampled on shift clock rise, result driven on fall
`timescale 1ns/1ns
`default_nettype none
`include "tsas_defs.svh"
module tsas_sequencer
  import tsas_pkg::*;
#(
  parameter int RES_BITS = 12
) (
  input  wire logic                clk,                // 125 MHz clock
  input  wire logic                reset,              // sync reset, high
  input  wire logic                serial_shift_clock, // host shift clock
  input  wire logic                serial_data_in,     // command pin
  input  wire logic                comparator_keep,    // comparator out
  input  wire logic                touch_sense_n,      // panel touched, low
  output var  logic                serial_data_out_r,  // result pin
  output var  logic                busy_r,             // converting
  output var  logic [RES_BITS-1:0] sar_code,           // cdac trial code
  output var  tsas_cmd_s           cmd_r,              // latched command
  output var  tsas_ana_s           ana_r,              // analog controls
  output var  logic                reference_power_r,  // ref powered
  output var  logic                converter_power_r,  // adc powered
  output var  logic                touch_alert_out_n_r // touch alert, low
);

  if (RES_BITS != 12) begin : g_chk
    $error("tsas_sequencer: RES_BITS must be twelve");
  end

  if (`TSAS_ACQ_AT_BIT >= `TSAS_CMD_BITS) begin : g_chk_acq
    $error("tsas_sequencer: acquisition must begin inside the command");
  end

  if (`TSAS_NEXT_12BIT > `TSAS_CNT_MAX) begin : g_chk_next
    $error("tsas_sequencer: overlap window beyond the counter range");
  end

  if (`TSAS_LAST_12BIT != RES_BITS - 1) begin : g_chk_last
    $error("tsas_sequencer: last step must match RES_BITS");
  end

  // ---------------------------------------------------------------
  // pin synchronisation and shift clock edges
  // ---------------------------------------------------------------
  logic [3:0] pins_s;
  logic       sclk_s;
  logic       din_s;
  logic       comp_s;
  logic       touch_n_s;
  logic       sclk_d_r;
  logic       rise;
  logic       fall;

  tsas_sync #(
    .WIDTH (4)
  ) u_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in ({serial_shift_clock, serial_data_in,
                comparator_keep, touch_sense_n}),
    .sync_out (pins_s)
  );

  assign sclk_s    = pins_s[3];
  assign din_s     = pins_s[2];
  assign comp_s    = pins_s[1];
  assign touch_n_s = pins_s[0];

  always_ff @(posedge clk) begin
    if (reset) begin
      sclk_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
    end
  end

  // edges show two clocks after the pin moves
  assign rise = sclk_s & ~sclk_d_r;
  assign fall = ~sclk_s & sclk_d_r;

  // ---------------------------------------------------------------
  // decoding helpers
  // ---------------------------------------------------------------
  function automatic logic chan_is(input logic [2:0] ch,
                                   input logic [2:0] code);
    chan_is = (ch == code);
  endfunction : chan_is

  function automatic logic [3:0] last_step(input logic res8);
    last_step = res8 ? `TSAS_LAST_8BIT : `TSAS_LAST_12BIT;
  endfunction : last_step

  // ---------------------------------------------------------------
  // command receiver
  // ---------------------------------------------------------------
  tsas_rx_e   rx_state_r;
  tsas_rx_e   rx_state_nxt;
  logic [4:0] rx_cnt_r;
  logic [4:0] rx_cnt_nxt;
  logic [7:0] shreg_r;
  logic [7:0] shreg_nxt;
  tsas_cmd_s  cmd_nxt;
  logic       acq_pend_r;
  logic       acq_pend_nxt;
  logic       conv_pend_r;
  logic       conv_pend_nxt;
  logic       accept;

  tsas_cv_e   cv_state_r;
  tsas_cv_e   cv_state_nxt;
  logic       cv_res8_r;

  // overlap window opens once enough clocks of the running command pass
  assign accept = (cv_state_r == TSAS_CV_IDLE) ||                 // [R2]
                  (rx_cnt_r >= (cv_res8_r ? `TSAS_NEXT_8BIT
                                          : `TSAS_NEXT_12BIT));   // [R19]

  always_comb begin
    rx_state_nxt  = rx_state_r;
    rx_cnt_nxt    = rx_cnt_r;
    shreg_nxt     = shreg_r;
    cmd_nxt       = cmd_r;
    acq_pend_nxt  = acq_pend_r;
    conv_pend_nxt = conv_pend_r;
    if (fall && acq_pend_r &&
        (cv_state_nxt == TSAS_CV_ACQ)) begin
      acq_pend_nxt = 1'b0;
    end
    if (fall && conv_pend_r &&
        (cv_state_nxt == TSAS_CV_CONV)) begin
      conv_pend_nxt = 1'b0;
    end
    if (rise) begin
      case (rx_state_r)
        TSAS_RX_IDLE: begin
          if (accept && din_s) begin                              // [R1]
            rx_state_nxt = TSAS_RX_CMD;
            rx_cnt_nxt   = 5'h01;
            shreg_nxt    = 8'h01;
          end else if (rx_cnt_r != `TSAS_CNT_MAX) begin
            rx_cnt_nxt = rx_cnt_r + 5'h01;
          end
        end
        TSAS_RX_CMD: begin
          shreg_nxt  = {shreg_r[6:0], din_s};                     // [R8]
          rx_cnt_nxt = rx_cnt_r + 5'h01;
          if (rx_cnt_nxt == `TSAS_ACQ_AT_BIT) begin
            // channel and resolution known: acquisition may begin
            cmd_nxt.channel_select = shreg_nxt[3:1];              // [R3]
            cmd_nxt.res_8bit       = shreg_nxt[0];                // [R4]
            acq_pend_nxt           = 1'b1;                        // [R8]
          end
          if (rx_cnt_nxt == `TSAS_CMD_BITS) begin
            cmd_nxt.channel_select =
              shreg_nxt[`TSAS_CHAN_MSB:`TSAS_CHAN_LSB];
            cmd_nxt.res_8bit              = shreg_nxt[`TSAS_MODE_POS];
            cmd_nxt.reference_mode_select = shreg_nxt[`TSAS_REF_POS]; // [R5]
            cmd_nxt.reference_power_bit   = shreg_nxt[`TSAS_PD1_POS]; // [R6]
            cmd_nxt.converter_power_bit   = shreg_nxt[`TSAS_PD0_POS]; // [R6]
            conv_pend_nxt                 = 1'b1;                 // [R9]
            rx_state_nxt                  = TSAS_RX_IDLE;
          end
        end
        default: begin
          rx_state_nxt = TSAS_RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_state_r  <= TSAS_RX_IDLE;
      rx_cnt_r    <= 5'h00;
      shreg_r     <= 8'h00;
      cmd_r       <= '0;
      acq_pend_r  <= 1'b0;
      conv_pend_r <= 1'b0;
    end else begin
      rx_state_r  <= rx_state_nxt;
      rx_cnt_r    <= rx_cnt_nxt;
      shreg_r     <= shreg_nxt;
      cmd_r       <= cmd_nxt;
      acq_pend_r  <= acq_pend_nxt;
      conv_pend_r <= conv_pend_nxt;
    end
  end

  // ---------------------------------------------------------------
  // conversion sequencer
  // ---------------------------------------------------------------
  logic [3:0] cv_step_r;
  logic [3:0] cv_step_nxt;
  logic       cv_res8_nxt;
  logic       cv_diff_r;
  logic       cv_diff_nxt;
  logic       dout_nxt;
  logic       alert_en_r;
  logic       alert_en_nxt;
  logic       sar_start;
  logic       sar_step;
  logic       sar_bit;
  logic       last;

  // last step decides the lsb of the chosen resolution
  assign last = (cv_step_r == last_step(cv_res8_r));

  always_comb begin
    cv_state_nxt = cv_state_r;
    cv_step_nxt  = cv_step_r;
    cv_res8_nxt  = cv_res8_r;
    cv_diff_nxt  = cv_diff_r;
    dout_nxt     = serial_data_out_r;
    alert_en_nxt = alert_en_r;
    sar_start    = 1'b0;
    if (fall) begin
      case (cv_state_r)
        TSAS_CV_CONV: begin
          dout_nxt    = sar_bit;                                  // [R22]
          cv_step_nxt = cv_step_r + 4'h1;                         // [R10]
          if (last) begin
            // end of conversion: alert re-enabled only when the converter power bit is low
            alert_en_nxt = ~cmd_r.converter_power_bit;            // [R21]
            cv_state_nxt = cv_diff_r ? TSAS_CV_TAIL               // [R11]
                                     : TSAS_CV_IDLE;
          end
        end
        TSAS_CV_ACQ: begin
          // pad clocks of an overlapped result fall here
          dout_nxt = 1'b0;                                        // [R12]
          if (conv_pend_r) begin
            cv_state_nxt = TSAS_CV_CONV;                          // [R9]
            cv_step_nxt  = 4'h0;
            cv_diff_nxt  = ~cmd_r.reference_mode_select;
            sar_start    = 1'b1;
          end
        end
        TSAS_CV_TAIL: begin
          dout_nxt     = 1'b0;                                    // [R12]
          cv_state_nxt = TSAS_CV_IDLE;
        end
        TSAS_CV_IDLE: begin
          dout_nxt = 1'b0;                                        // [R12]
        end
        default: begin
          cv_state_nxt = TSAS_CV_IDLE;
          dout_nxt     = 1'b0;
        end
      endcase
      // a new command takes over once the running result is complete
      if (acq_pend_r && ((cv_state_r != TSAS_CV_CONV) || last)) begin
        cv_state_nxt = TSAS_CV_ACQ;                               // [R19]
        cv_res8_nxt  = cmd_r.res_8bit;                            // [R4]
        alert_en_nxt = 1'b0;
      end
    end
  end

  assign sar_step = rise && (cv_state_r == TSAS_CV_CONV);         // [R10]

  tsas_sar #(
    .BITS (RES_BITS)
  ) u_sar (
    .clk             (clk),
    .reset           (reset),
    .start           (sar_start),
    .step            (sar_step),
    .comparator_keep (comp_s),
    .trial_code_r    (sar_code),
    .decided_r       (sar_bit)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      cv_state_r        <= TSAS_CV_IDLE;
      cv_step_r         <= 4'h0;
      cv_res8_r         <= 1'b0;
      cv_diff_r         <= 1'b0;
      serial_data_out_r <= 1'b0;
      alert_en_r        <= 1'b1;
    end else begin
      cv_state_r        <= cv_state_nxt;
      cv_step_r         <= cv_step_nxt;
      cv_res8_r         <= cv_res8_nxt;
      cv_diff_r         <= cv_diff_nxt;
      serial_data_out_r <= dout_nxt;
      alert_en_r        <= alert_en_nxt;
    end
  end

  // ---------------------------------------------------------------
  // analog controls, power and touch alert
  // ---------------------------------------------------------------
  tsas_ana_s ana_nxt;
  logic      busy_nxt;
  logic      ref_pwr_nxt;
  logic      conv_pwr_nxt;
  logic      alert_n_nxt;
  logic      acq_nxt;

  always_comb begin
    acq_nxt = (cv_state_nxt == TSAS_CV_ACQ);
    ana_nxt.drivers_on =
      acq_nxt ||                                                  // [R8]
      ((cv_state_nxt == TSAS_CV_CONV) && cv_diff_nxt) ||          // [R11]
      (cv_state_nxt == TSAS_CV_TAIL);
    ana_nxt.sample_hold = (cv_state_nxt == TSAS_CV_CONV) ||       // [R9]
                          (cv_state_nxt == TSAS_CV_TAIL);
    ana_nxt.diode_low_current_sample = acq_nxt &&                 // [R15]
      chan_is(cmd_nxt.channel_select, `TSAS_CH_DIODE_LOW);        // [R13]
    ana_nxt.diode_high_current_sample = acq_nxt &&                // [R15]
      chan_is(cmd_nxt.channel_select, `TSAS_CH_DIODE_HIGH);       // [R14]
    ana_nxt.battery_divider_on = acq_nxt &&                       // [R16]
      chan_is(cmd_nxt.channel_select, `TSAS_CH_BATTERY);
    ana_nxt.ref_from_pin = cmd_nxt.reference_mode_select;         // [R17]
    busy_nxt     = (cv_state_nxt == TSAS_CV_CONV);
    ref_pwr_nxt  = cmd_nxt.reference_power_bit;                   // [R20]
    conv_pwr_nxt = cmd_nxt.converter_power_bit ||                 // [R20]
                   (cv_state_nxt != TSAS_CV_IDLE);
    alert_n_nxt  = alert_en_nxt ? touch_n_s : 1'b1;               // [R21]
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ana_r               <= '0;
      busy_r              <= 1'b0;
      reference_power_r   <= 1'b0;
      converter_power_r   <= 1'b0;
      touch_alert_out_n_r <= 1'b1;
    end else begin
      ana_r               <= ana_nxt;
      busy_r              <= busy_nxt;
      reference_power_r   <= ref_pwr_nxt;
      converter_power_r   <= conv_pwr_nxt;
      touch_alert_out_n_r <= alert_n_nxt;
    end
  end

endmodule : tsas_sequencer
`default_nettype wire

// file: tsas_sequencer_properties.sv
// Purpose: port-level checks of the touch adc serial sequencer
// Assumes: shift clock period of eight system clocks
// Notes:   bound into tsas_sequencer below the module
`timescale 1ns/1ns
`default_nettype none
module tsas_sequencer_properties
  import tsas_pkg::*;
#(
  parameter int RES_BITS = 12
) (
  input wire logic                clk,                 // clock
  input wire logic                reset,               // sync reset
  input wire logic                serial_shift_clock,  // shift clock
  input wire logic                serial_data_in,      // command pin
  input wire logic                comparator_keep,     // comparator
  input wire logic                touch_sense_n,       // touch, low
  input wire logic                serial_data_out_r,   // result pin
  input wire logic                busy_r,              // converting
  input wire logic [RES_BITS-1:0] sar_code,            // trial code
  input wire tsas_cmd_s           cmd_r,               // command
  input wire tsas_ana_s           ana_r,               // analog ctrl
  input wire logic                reference_power_r,   // ref power
  input wire logic                converter_power_r,   // adc power
  input wire logic                touch_alert_out_n_r  // alert, low
);
  logic [7:0] bias_cnt_r, bias_cnt_nxt, busy_cnt_r, busy_cnt_nxt;
  logic [4:0] idle_cnt_r, idle_cnt_nxt;
  logic       bias_on;

  assign bias_on = ana_r.diode_low_current_sample
                 | ana_r.diode_high_current_sample | ana_r.battery_divider_on;

  always_comb begin
    bias_cnt_nxt = bias_on ? bias_cnt_r + 8'h01 : 8'h00;
    busy_cnt_nxt = busy_r ? busy_cnt_r + 8'h01 : 8'h00;
    idle_cnt_nxt = idle_cnt_r + {4'h0, idle_cnt_r != 5'h1F};
    if (busy_r) begin
      idle_cnt_nxt = 5'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bias_cnt_r <= 8'h00;
      busy_cnt_r <= 8'h00;
      idle_cnt_r <= 5'h00;
    end else begin
      bias_cnt_r <= bias_cnt_nxt;
      busy_cnt_r <= busy_cnt_nxt;
      idle_cnt_r <= idle_cnt_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_conv_start;
    $rose(busy_r);
  endsequence
  sequence s_conv_end;
    $fell(busy_r);
  endsequence

  a_diode_low: assert property (
    ana_r.diode_low_current_sample |-> cmd_r.channel_select == 3'h0)
    else $error("low diode bias outside channel zero");
  a_diode_high: assert property (
    ana_r.diode_high_current_sample |-> cmd_r.channel_select == 3'h7)
    else $error("high diode bias outside channel seven");
  a_battery_chan: assert property (
    ana_r.battery_divider_on |-> cmd_r.channel_select == 3'h2)
    else $error("battery divider on for another channel");
  a_bias_window: assert property (
    bias_on |-> !busy_r && bias_cnt_r < 8'h18)
    else $error("bias current outside acquisition");
  a_hold_conv: assert property (
    busy_r |-> ana_r.sample_hold)
    else $error("sample not held during conversion");
  a_se_drivers: assert property (
    busy_r && cmd_r.reference_mode_select |-> !ana_r.drivers_on)
    else $error("drivers on in single-ended conversion");
  a_diff_drivers: assert property (
    busy_r && !cmd_r.reference_mode_select |-> ana_r.drivers_on)
    else $error("drivers off in ratiometric conversion");
  a_ref_select: assert property (
    busy_r |-> ana_r.ref_from_pin == cmd_r.reference_mode_select)
    else $error("reference source does not follow mode");
  a_sar_msb: assert property (
    s_conv_start |-> ##[0:2] sar_code == {1'b1, {(RES_BITS-1){1'b0}}})
    else $error("conversion did not start at msb trial");
  a_busy_len: assert property (
    s_conv_end |-> busy_cnt_r inside {[8'h5F:8'h61], [8'h3F:8'h41]})
    else $error("conversion length wrong");
  a_dout_pad: assert property (
    idle_cnt_r > 5'h0B |-> !serial_data_out_r)
    else $error("result pin not low after conversion");
  a_alert_busy: assert property (
    busy_r |-> touch_alert_out_n_r)
    else $error("touch alert active during conversion");
  a_conv_power: assert property (
    busy_r |-> converter_power_r)
    else $error("converter unpowered while converting");
  a_alert_touch: assert property (
    !touch_alert_out_n_r |-> !$past(touch_sense_n, 3))
    else $error("touch alert low without a touch");
endmodule : tsas_sequencer_properties

bind tsas_sequencer tsas_sequencer_properties #(.RES_BITS(RES_BITS)) props_u (
  .clk(clk), .reset(reset), .serial_shift_clock(serial_shift_clock),
  .serial_data_in(serial_data_in), .comparator_keep(comparator_keep),
  .touch_sense_n(touch_sense_n), .serial_data_out_r(serial_data_out_r),
  .busy_r(busy_r), .sar_code(sar_code), .cmd_r(cmd_r), .ana_r(ana_r),
  .reference_power_r(reference_power_r),
  .converter_power_r(converter_power_r),
  .touch_alert_out_n_r(touch_alert_out_n_r)
);
`default_nettype wire

// file: tsas_sequencer_tb.sv
// Purpose: self-checking bench of the touch adc serial sequencer
// Assumes: comparator modelled against a fixed input code
// Notes:   panel held touched except for a short untouched spell after the first frame
`timescale 1ns/1ns
`default_nettype none
module tsas_sequencer_tb
  import tsas_pkg::*;
;
  localparam logic [11:0] target_code = 12'hA5D;
  logic        clk, reset, comparator_keep, touch_sense_n;
  logic        serial_shift_clock, serial_data_in, serial_data_out_r;
  logic        busy_r, reference_power_r, converter_power_r;
  logic        touch_alert_out_n_r;
  logic [11:0] sar_code;
  tsas_cmd_s   cmd_r;
  tsas_ana_s   ana_r;
  logic [31:0] got;
  logic [3:0]  seen_r;
  int          n_errors, checks, cycles;

  tsas_sequencer #(.RES_BITS(12)) dut_u (
    .clk(clk), .reset(reset), .serial_shift_clock(serial_shift_clock),
    .serial_data_in(serial_data_in), .comparator_keep(comparator_keep),
    .touch_sense_n(touch_sense_n), .serial_data_out_r(serial_data_out_r),
    .busy_r(busy_r), .sar_code(sar_code), .cmd_r(cmd_r), .ana_r(ana_r),
    .reference_power_r(reference_power_r),
    .converter_power_r(converter_power_r),
    .touch_alert_out_n_r(touch_alert_out_n_r)
  );
  tsas_host_model host_u (
    .clk(clk), .serial_data_out_r(serial_data_out_r),
    .serial_shift_clock(serial_shift_clock), .serial_data_in(serial_data_in)
  );

  always #4 clk = ~clk;

  // comparator and a record of controls seen during a frame
  always @(posedge clk) begin
    comparator_keep <= target_code >= sar_code;
    seen_r <= seen_r | {ana_r.diode_low_current_sample,
      ana_r.diode_high_current_sample, ana_r.battery_divider_on,
      busy_r & ana_r.drivers_on};
    cycles <= cycles + 1;
    if (cycles == 32'h0000_4E20) begin
      n_errors = n_errors + 1;
      complete_run();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, exp);
    checks = checks + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic frame(input logic [31:0] bits, input int n);
    @(negedge clk) seen_r = 4'h0;
    host_u.xfer(bits, n, got);
    repeat (12) @(posedge clk);
  endtask : frame

  task automatic complete_run;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    comparator_keep = 1'b0;
    touch_sense_n = 1'b0;
    seen_r = 4'h0;
    n_errors = 0;
    checks = 0;
    cycles = 0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (8) @(posedge clk);
    frame({3'b000, 8'h94, 21'h0}, 27);
    check("result", got[14:0], {target_code, 3'b000});
    check("command", cmd_r, 7'h14);
    check("alert", touch_alert_out_n_r, 1'b0);
    touch_sense_n <= 1'b1;
    repeat (5) @(posedge clk);
    check("alert", touch_alert_out_n_r, 1'b1);
    touch_sense_n <= 1'b0;
    frame({8'hBD, 24'h0}, 24);
    check("result", got[14:0], {target_code[11:4], 7'h00});
    check("alert", touch_alert_out_n_r, 1'b1);
    check("power", {reference_power_r, converter_power_r}, 2'b01);
    for (int c = 0; c < 8; c++) begin
      frame({1'b1, c[2:0], 4'hF, 24'h0}, 24);
      check("channel", cmd_r.channel_select, c[2:0]);
      check("ctl", seen_r, {c == 0, c == 7, c == 2, 1'b0});
      check("result", got[14:0], {target_code[11:4], 7'h00});
    end
    for (int p = 0; p < 4; p++) begin
      frame({5'b10010, 1'b0, p[1:0], 24'h0}, 24);
      check("result", got[14:0], {target_code, 3'b000});
      check("drivers", seen_r[0], 1'b1);
      check("power", {reference_power_r, converter_power_r}, p[1:0]);
      check("alert", touch_alert_out_n_r, p[0]);
    end
    frame({8'h94, 8'h08, 16'h0}, 24);
    check("command", cmd_r, 7'h14);
    check("result", got[14:0], {target_code, 3'b000});
    frame({8'hA7, 7'h00, 8'hD3, 9'h000}, 30);
    check("first", got[20:9], target_code);
    check("pad", got[8:0], {3'b000, target_code[11:6]});
    check("second", cmd_r, 7'h53);
    check("battery", seen_r[1], 1'b1);
    complete_run();
  end
endmodule : tsas_sequencer_tb
`default_nettype wire

// file: tsas_sync.sv
// Purpose: two-stage synchroniser for pins from outside the clock domain
// Assumes: each bit is an independent level
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none
module tsas_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk,      // system clock
  input  wire logic             reset,    // sync reset, high
  input  wire logic [WIDTH-1:0] async_in, // raw pins
  output var  logic [WIDTH-1:0] sync_out  // synchronised levels
);

  if (WIDTH < 1) begin : g_chk
    $error("tsas_sync: WIDTH must be at least one");
  end

  logic [WIDTH-1:0] meta_r;

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (reset) begin
        meta_r[i]   <= 1'b0;
        sync_out[i] <= 1'b0;
      end else begin
        meta_r[i]   <= async_in[i];
        sync_out[i] <= meta_r[i];
      end
    end
  end

endmodule : tsas_sync
`default_nettype wire
